// ===== src/mpc_map.vh
`ifndef MPC_MAP_VH
`define MPC_MAP_VH

// Register indices; byte address is four times the index
`define MPC_IDX_ACCESS 8'h06
`define MPC_IDX_DATA 8'h07
`define MPC_IDX_PAUSE 8'h08
`define MPC_IDX_MAC_CTRL 8'h10
`define MPC_ADDR_W 8

// Access register fields
`define MPC_ACC_PHY_HI 15
`define MPC_ACC_PHY_LO 11
`define MPC_ACC_IDX_HI 10
`define MPC_ACC_IDX_LO 6
`define MPC_ACC_WSEL 1
`define MPC_ACC_BUSY 0
`define MPC_ACC_MASK 32'h0000_FFC3

// Data register fields
`define MPC_DATA_MASK 32'h0000_FFFF

// Pause control fields
`define MPC_PC_TIME_HI 31
`define MPC_PC_TIME_LO 16
`define MPC_PC_PASS 2
`define MPC_PC_EN 1
`define MPC_PC_BUSY 0

// Mac control fields
`define MPC_MC_FDX 0
`define MPC_MC_TXEN 1
`define MPC_MC_PROMISC 2
`define MPC_MC_MASK 32'h0000_0007

`define MPC_RESET_VAL 32'h0000_0000
`define MPC_INT_PHY_ADDR 5'h01

// Timing
`define MPC_CLK_NS 8
`define MPC_SLOT_NS 5120
`define MPC_SLOT_CYC (`MPC_SLOT_NS / `MPC_CLK_NS)
`define MPC_MDC_HALF_NS 200
`define MPC_MDC_HALF_CYC (`MPC_MDC_HALF_NS / `MPC_CLK_NS)
`define MPC_MDIO_BITS 64
`define MPC_MDIO_TA_BIT 46
`define MPC_MDIO_DATA_BIT 48

// Bus responses
`define MPC_RESP_OKAY 2'b00
`define MPC_RESP_SLVERR 2'b10

`endif

// ===== src/mpc_mdio.v
`timescale 1ns/100ps
`include "mpc_map.vh"

module mpc_mdio #(
  parameter HALF_CYC = `MPC_MDC_HALF_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire write_sel,
  input wire [4:0] phy_addr,
  input wire [4:0] reg_idx,
  input wire [15:0] wr_data,
  output reg done,
  output reg [15:0] rd_data,
  output reg mdc,
  output wire mdio_o,
  output wire mdio_oe_n,
  input wire mdio_i
);
  reg active_r;
  reg wsel_r;
  reg [5:0] bit_r;
  reg [63:0] sh_r;
  reg [15:0] div_r;
  wire tick = (div_r == HALF_CYC - 1);

  assign mdio_o = sh_r[63];
  // Read frames release the line from turnaround on
  assign mdio_oe_n = ~(active_r & (wsel_r | (bit_r < `MPC_MDIO_TA_BIT)));

  always @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= 1'b0;
      wsel_r <= 1'b0;
      bit_r <= 6'h00;
      sh_r <= 64'h0000_0000_0000_0000;
      div_r <= 16'h0000;
      mdc <= 1'b0;
      done <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!active_r) begin
        mdc <= 1'b0;
        div_r <= 16'h0000;
        if (start) begin
          // Preamble, start, opcode, addresses, turnaround, data
          active_r <= 1'b1;
          wsel_r <= write_sel;
          bit_r <= 6'h00;
          sh_r <= {32'hFFFF_FFFF, 2'b01, write_sel ? 2'b01 : 2'b10,
                   phy_addr, reg_idx, 2'b10, write_sel ? wr_data : 16'hFFFF};
        end
      end else begin
        div_r <= tick ? 16'h0000 : div_r + 16'h0001;
        if (tick) begin
          mdc <= ~mdc;
          if (!mdc) begin
            if (!wsel_r && bit_r >= `MPC_MDIO_DATA_BIT)
              rd_data <= {rd_data[14:0], mdio_i};
          end else if (bit_r == `MPC_MDIO_BITS - 1) begin
            active_r <= 1'b0;
            done <= 1'b1;
          end else begin
            bit_r <= bit_r + 6'h01;
            sh_r <= {sh_r[62:0], 1'b1};
          end
        end
      end
    end
  end
endmodule // mpc_mdio

// ===== src/mpc_pause.v
`timescale 1ns/100ps
`include "mpc_map.vh"

module mpc_pause #(
  parameter SLOT_CYC = `MPC_SLOT_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire full_duplex,
  input wire tx_enable,
  input wire flow_en,
  input wire pause_req,
  input wire pause_frame_sent,
  input wire bp_req,
  input wire rx_pause_valid,
  input wire [15:0] rx_pause_quanta,
  output reg pause_frame_req,
  output wire back_pressure,
  output wire tx_halt,
  output wire busy
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  reg state_r;
  reg [15:0] quanta_r;
  reg [15:0] slot_r;
  wire slot_tick = (slot_r == SLOT_CYC - 1);

  // Half duplex: flow enable drives back pressure instead of pause
  assign back_pressure = ~full_duplex & flow_en & tx_enable & bp_req;
  assign busy = (state_r == ST_SEND) | back_pressure;
  assign tx_halt = (quanta_r != 16'h0000);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      pause_frame_req <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (pause_req && full_duplex && tx_enable) begin
            state_r <= ST_SEND;
            pause_frame_req <= 1'b1;
          end
        end
        ST_SEND: begin
          // Dropping tx enable aborts a frame not yet on the wire
          if (pause_frame_sent || !tx_enable) begin
            state_r <= ST_IDLE;
            pause_frame_req <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          pause_frame_req <= 1'b0;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      quanta_r <= 16'h0000;
      slot_r <= 16'h0000;
    end else if (rx_pause_valid && full_duplex && flow_en) begin
      quanta_r <= rx_pause_quanta;
      slot_r <= 16'h0000;
    end else if (!full_duplex || !flow_en) begin
      quanta_r <= 16'h0000;
      slot_r <= 16'h0000;
    end else if (quanta_r != 16'h0000) begin
      slot_r <= slot_tick ? 16'h0000 : slot_r + 16'h0001;
      if (slot_tick)
        quanta_r <= quanta_r - 16'h0001;
    end
  end
endmodule // mpc_pause

// ===== src/mpc_top.v
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "mpc_map.vh"

module mpc_top #(
  parameter SLOT_CYC = `MPC_SLOT_CYC,
  parameter MDC_HALF_CYC = `MPC_MDC_HALF_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [`MPC_ADDR_W+1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`MPC_ADDR_W+1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire mdc,
  output wire mdio_o,
  output wire mdio_oe_n,
  input wire mdio_i,
  input wire pause_req,
  output wire pause_frame_req,
  output wire [15:0] pause_time_value,
  input wire pause_frame_sent,
  input wire bp_req,
  output wire back_pressure,
  output wire tx_halt,
  input wire rx_pause_valid,
  input wire [15:0] rx_pause_quanta,
  input wire rx_frame_valid,
  input wire [7:0] rx_data_in,
  input wire rx_is_pause,
  input wire rx_filter_pass_in,
  output reg rx_frame_valid_out,
  output reg [7:0] rx_data_out,
  output reg rx_filter_pass_out
);
  reg [`MPC_ADDR_W+1:0] aw_addr_r;
  reg aw_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_held_r;

  reg [4:0] phy_addr_r;
  reg [4:0] phy_reg_index_r;
  reg phy_mgmt_write_sel_r;
  reg phy_mgmt_busy_r;
  reg mdio_start_r;
  reg [15:0] phy_data_r;
  reg [15:0] pause_time_r;
  reg pass_ctrl_frames_r;
  reg pause_rx_enable_r;
  reg [2:0] mac_ctrl_r;

  wire mdio_done;
  wire [15:0] mdio_rd_data;
  wire pause_tx_busy;
  wire full_duplex = mac_ctrl_r[`MPC_MC_FDX];
  wire tx_enable = mac_ctrl_r[`MPC_MC_TXEN];
  wire promisc = mac_ctrl_r[`MPC_MC_PROMISC];

  wire [`MPC_ADDR_W-1:0] wr_idx = aw_addr_r[`MPC_ADDR_W+1:2];
  wire [`MPC_ADDR_W-1:0] rd_idx = s_axi_araddr[`MPC_ADDR_W+1:2];
  wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                           {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  reg [31:0] acc_rd;
  reg [31:0] data_rd;
  reg [31:0] pause_rd;
  reg [31:0] mc_rd;
  reg [31:0] acc_new;
  reg [31:0] data_new;
  reg [31:0] pause_new;
  reg [31:0] mc_new;

  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready = ~w_held_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign pause_time_value = pause_time_r;

  // Readback views; reserved bits are constant zero
  always @* begin
    acc_rd = `MPC_RESET_VAL;
    acc_rd[`MPC_ACC_PHY_HI:`MPC_ACC_PHY_LO] = phy_addr_r;
    acc_rd[`MPC_ACC_IDX_HI:`MPC_ACC_IDX_LO] = phy_reg_index_r;
    acc_rd[`MPC_ACC_WSEL] = phy_mgmt_write_sel_r;
    acc_rd[`MPC_ACC_BUSY] = phy_mgmt_busy_r;
    data_rd = {16'h0000, phy_data_r};
    pause_rd = `MPC_RESET_VAL;
    pause_rd[`MPC_PC_TIME_HI:`MPC_PC_TIME_LO] = pause_time_r;
    pause_rd[`MPC_PC_PASS] = pass_ctrl_frames_r;
    pause_rd[`MPC_PC_EN] = pause_rx_enable_r;
    pause_rd[`MPC_PC_BUSY] = pause_tx_busy;
    mc_rd = {29'h0000_0000, mac_ctrl_r};
  end

  // Byte-lane merge of held write data into each register view
  always @* begin
    acc_new = ((acc_rd & ~strb_mask) | (w_data_r & strb_mask)) & `MPC_ACC_MASK;
    data_new = ((data_rd & ~strb_mask) | (w_data_r & strb_mask)) & `MPC_DATA_MASK;
    pause_new = (pause_rd & ~strb_mask) | (w_data_r & strb_mask);
    mc_new = ((mc_rd & ~strb_mask) | (w_data_r & strb_mask)) & `MPC_MC_MASK;
  end

  // Write channel: address and data held independently
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= {(`MPC_ADDR_W+2){1'b0}};
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Holes in the map answer SLVERR and change nothing
        case (wr_idx)
          `MPC_IDX_ACCESS, `MPC_IDX_DATA, `MPC_IDX_PAUSE, `MPC_IDX_MAC_CTRL:
            s_axi_bresp <= `MPC_RESP_OKAY;
          default:
            s_axi_bresp <= `MPC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register state and management cycle launch
  always @(posedge aclk) begin
    if (!aresetn) begin
      phy_addr_r <= 5'h00;
      phy_reg_index_r <= 5'h00;
      phy_mgmt_write_sel_r <= 1'b0;
      phy_mgmt_busy_r <= 1'b0;
      mdio_start_r <= 1'b0;
      phy_data_r <= 16'h0000;
      pause_time_r <= 16'h0000;
      pass_ctrl_frames_r <= 1'b0;
      pause_rx_enable_r <= 1'b0;
      mac_ctrl_r <= 3'h0;
    end else begin
      mdio_start_r <= 1'b0;
      if (mdio_done) begin
        phy_mgmt_busy_r <= 1'b0;
        if (!phy_mgmt_write_sel_r)
          phy_data_r <= mdio_rd_data;
      end
      // Writes to the access or data register during a cycle are dropped,
      // protecting the frame in flight from careless software
      if (wr_go && wr_idx == `MPC_IDX_ACCESS && !phy_mgmt_busy_r) begin
        phy_addr_r <= acc_new[`MPC_ACC_PHY_HI:`MPC_ACC_PHY_LO];
        phy_reg_index_r <= acc_new[`MPC_ACC_IDX_HI:`MPC_ACC_IDX_LO];
        phy_mgmt_write_sel_r <= acc_new[`MPC_ACC_WSEL];
        if (acc_new[`MPC_ACC_BUSY]) begin
          phy_mgmt_busy_r <= 1'b1;
          mdio_start_r <= 1'b1;
        end
      end
      if (wr_go && wr_idx == `MPC_IDX_DATA && !phy_mgmt_busy_r)
        phy_data_r <= data_new[15:0];
      // Taken even while pause busy; waiting for idle is software's duty
      if (wr_go && wr_idx == `MPC_IDX_PAUSE) begin
        pause_time_r <= pause_new[`MPC_PC_TIME_HI:`MPC_PC_TIME_LO];
        pass_ctrl_frames_r <= pause_new[`MPC_PC_PASS];
        pause_rx_enable_r <= pause_new[`MPC_PC_EN];
        // Busy position is status only; written value is ignored
      end
      // Local duplex, transmit and filter mode bits
      if (wr_go && wr_idx == `MPC_IDX_MAC_CTRL)
        mac_ctrl_r <= mc_new[2:0];
    end
  end

  // Read channel: one cycle answer, unmapped reads zero with error
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MPC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `MPC_RESP_OKAY;
      case (rd_idx)
        `MPC_IDX_ACCESS: s_axi_rdata <= acc_rd;
        `MPC_IDX_DATA: s_axi_rdata <= data_rd;
        `MPC_IDX_PAUSE: s_axi_rdata <= pause_rd;
        `MPC_IDX_MAC_CTRL: s_axi_rdata <= mc_rd;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `MPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Receive status path; data is never gated, only the filter verdict
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_frame_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_filter_pass_out <= 1'b0;
    end else begin
      rx_frame_valid_out <= rx_frame_valid;
      rx_data_out <= rx_data_in;
      if (promisc)
        rx_filter_pass_out <= rx_filter_pass_in;
      else if (rx_is_pause)
        rx_filter_pass_out <= rx_filter_pass_in & pass_ctrl_frames_r;
      else
        rx_filter_pass_out <= rx_filter_pass_in;
    end
  end

  mpc_mdio #(
    .HALF_CYC(MDC_HALF_CYC)
  ) u_mdio (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(mdio_start_r),
    .write_sel(phy_mgmt_write_sel_r),
    .phy_addr(phy_addr_r),
    .reg_idx(phy_reg_index_r),
    .wr_data(phy_data_r),
    .done(mdio_done),
    .rd_data(mdio_rd_data),
    .mdc(mdc),
    .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n),
    .mdio_i(mdio_i)
  );

  mpc_pause #(
    .SLOT_CYC(SLOT_CYC)
  ) u_pause (
    .aclk(aclk),
    .aresetn(aresetn),
    .full_duplex(full_duplex),
    .tx_enable(tx_enable),
    .flow_en(pause_rx_enable_r),
    .pause_req(pause_req),
    .pause_frame_sent(pause_frame_sent),
    .bp_req(bp_req),
    .rx_pause_valid(rx_pause_valid),
    .rx_pause_quanta(rx_pause_quanta),
    .pause_frame_req(pause_frame_req),
    .back_pressure(back_pressure),
    .tx_halt(tx_halt),
    .busy(pause_tx_busy)
  );
endmodule // mpc_top

// ===== sim/mpc_top_chk.sv
`timescale 1ns/100ps
module mpc_top_chk #(
  parameter SLOT_CYC = 640
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe_n,
  input wire pause_req,
  input wire pause_frame_req,
  input wire pause_frame_sent,
  input wire bp_req,
  input wire back_pressure,
  input wire tx_halt,
  input wire rx_pause_valid,
  input wire [15:0] rx_pause_quanta,
  input wire rx_frame_valid,
  input wire [7:0] rx_data_in,
  input wire rx_is_pause,
  input wire rx_filter_pass_in,
  input wire rx_frame_valid_out,
  input wire [7:0] rx_data_out,
  input wire rx_filter_pass_out
);
  reg [31:0] halt_cnt_r;
  reg [15:0] quanta_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts cycles of an active halt; assumes no second pause frame while halted
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_cnt_r <= 32'h0000_0000;
      quanta_r <= 16'h0000;
    end else begin
      halt_cnt_r <= tx_halt ? halt_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      if (rx_pause_valid)
        quanta_r <= rx_pause_quanta;
    end
  end
  a_req_cause: assert property ($rose(pause_frame_req) |-> $past(pause_req))
    else $error("pause frame request without cause");
  a_req_release: assert property (pause_frame_req && pause_frame_sent |=> !pause_frame_req)
    else $error("pause frame request kept after frame sent");
  a_bp_cause: assert property (back_pressure |-> bp_req)
    else $error("back pressure without request");
  a_halt_cause: assert property ($rose(tx_halt) |-> $past(rx_pause_valid))
    else $error("transmit halt without received pause");
  a_halt_length: assert property ($fell(tx_halt) |-> halt_cnt_r == quanta_r * SLOT_CYC)
    else $error("transmit halt length wrong");
  a_rx_forward: assert property ($past(aresetn) |-> rx_frame_valid_out == $past(rx_frame_valid)
    && rx_data_out == $past(rx_data_in))
    else $error("receive data not forwarded");
  a_filter_plain: assert property ($past(aresetn) && !$past(rx_is_pause)
    |-> rx_filter_pass_out == $past(rx_filter_pass_in))
    else $error("filter status changed on plain frame");
  a_filter_cause: assert property ($past(aresetn) && rx_filter_pass_out
    |-> $past(rx_filter_pass_in))
    else $error("filter status raised without input");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_mdio_steady: assert property (mdc && $past(mdc) |-> $stable(mdio_o) && $stable(mdio_oe_n))
    else $error("management data moved while clock high");
endmodule // mpc_top_chk

// ===== sim/mpc_phy_model.sv
`timescale 1ns/100ps
module mpc_phy_model #(
  parameter PHY_ADDR = 5'h01,
  parameter SENT_DLY = 40
) (
  input wire aclk,
  input wire mdc,
  input wire mdio,
  output reg drv_en,
  output reg drv_bit,
  output reg [13:0] last_hdr,
  output reg [15:0] last_wdata,
  output reg preamble_ok,
  input wire pause_frame_req,
  output wire pause_frame_sent
);
  reg [15:0] regs [0:31];
  reg [63:0] sh;
  reg rd_op = 1'b0;
  reg hit = 1'b0;
  reg [4:0] ridx = 5'h00;
  reg [7:0] cnt = 8'h00;
  integer n = 0;
  integer i;
  initial begin
    for (i = 0; i < 32; i = i + 1)
      regs[i] = 16'h5A00 | i;
    drv_en = 1'b0;
    drv_bit = 1'b1;
  end
  always @(posedge mdc) begin
    sh = {sh[62:0], mdio};
    n = n + 1;
    if (n == 46) begin
      last_hdr = sh[13:0];
      preamble_ok = &sh[45:14];
      rd_op = (sh[11:10] == 2'b10);
      hit = (sh[9:5] == PHY_ADDR);
      ridx = sh[4:0];
    end
    if (n == 64) begin
      if (!rd_op && hit)
        regs[ridx] = sh[15:0];
      last_wdata = sh[15:0];
      n = 0;
    end
  end
  // Other PHYs stay off the line, so the pull-up shows through
  always @(negedge mdc) begin
    drv_en = rd_op && hit && n >= 47 && n <= 63;
    drv_bit = (n == 47) ? 1'b0 : regs[ridx][63 - n];
  end
  always @(posedge aclk)
    cnt <= pause_frame_req ? cnt + 8'h01 : 8'h00;
  assign pause_frame_sent = pause_frame_req && (cnt == SENT_DLY);
endmodule // mpc_phy_model

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`include "mpc_map.vh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mdc, mdio_o, mdio_oe_n, mdio_i, phy_en, phy_bit, preamble_ok;
  logic pause_req = 1'b0, bp_req = 1'b0, rx_pause_valid = 1'b0;
  logic pause_frame_req, pause_frame_sent, back_pressure, tx_halt;
  logic [15:0] pause_time_value, last_wdata, rx_pause_quanta = 16'h0002;
  logic rx_frame_valid = 1'b0, rx_is_pause = 1'b0, rx_filter_pass_in = 1'b0;
  logic [7:0] rx_data_in = '0, rx_data_out;
  logic rx_frame_valid_out, rx_filter_pass_out;
  logic [13:0] last_hdr;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  assign mdio_i = !mdio_oe_n ? mdio_o : (phy_en ? phy_bit : 1'b1);
  always #4 aclk = ~aclk;
  mpc_top #(.SLOT_CYC(4), .MDC_HALF_CYC(2)) i_mpc_top (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mdc, .mdio_o, .mdio_oe_n,
    .mdio_i, .pause_req, .pause_frame_req, .pause_time_value, .pause_frame_sent, .bp_req,
    .back_pressure, .tx_halt, .rx_pause_valid, .rx_pause_quanta, .rx_frame_valid, .rx_data_in,
    .rx_is_pause, .rx_filter_pass_in, .rx_frame_valid_out, .rx_data_out, .rx_filter_pass_out);
  mpc_phy_model i_mpc_phy_model (.aclk, .mdc, .mdio(mdio_i), .drv_en(phy_en),
    .drv_bit(phy_bit), .last_hdr, .last_wdata, .preamble_ok, .pause_frame_req,
    .pause_frame_sent);
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic pulse(input bit rx);
    @(posedge aclk);
    if (rx)
      rx_pause_valid <= 1'b1;
    else
      pause_req <= 1'b1;
    @(posedge aclk);
    rx_pause_valid <= 1'b0;
    pause_req <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~{idx, 2'b00};
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Ready is raised late on purpose so the slave must hold its answer
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er = 2'b00);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~{idx, 2'b00};
      end else if (!ar && s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) begin
        s_axi_rready <= 1'b1;
      end
    end while (s_axi_rready !== 1'b1 || s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] g;
    rd(idx, g);
    chk(nm, e, g);
  endtask
  task automatic mgmt(input logic [31:0] acc);
    logic [31:0] g;
    int n;
    wr(`MPC_IDX_ACCESS, acc);
    rc(`MPC_IDX_ACCESS, acc, "busy_set");
    wr(`MPC_IDX_DATA, 32'h0000_0BAD);
    n = 0;
    do begin
      rd(`MPC_IDX_ACCESS, g);
      n++;
    end while (g[0] !== 1'b0 && n < 300);
    chk("busy_clear", 32'h0000_0000, {31'h0, g[0]});
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    tick(20);
    aresetn <= 1'b1;
    rc(`MPC_IDX_ACCESS, 32'h0000_0000, "access_rst");
    rc(`MPC_IDX_DATA, 32'h0000_0000, "data_rst");
    rc(`MPC_IDX_PAUSE, 32'h0000_0000, "pause_rst");
    rd(8'h05, v, 2'b10);
    wr(8'h05, 32'h0000_0001, 2'b10);
    wr(`MPC_IDX_ACCESS, 32'hFFFF_FFFC);
    rc(`MPC_IDX_ACCESS, 32'h0000_FFC0, "access_rsv");
    wr(`MPC_IDX_PAUSE, 32'hFFFF_FFFE);
    rc(`MPC_IDX_PAUSE, 32'hFFFF_0006, "pause_rsv");
    wr(`MPC_IDX_DATA, 32'hFFFF_ABCD);
    rc(`MPC_IDX_DATA, 32'h0000_ABCD, "data_rsv");
    wr(`MPC_IDX_MAC_CTRL, 32'h0000_0003);
    mgmt({16'h0000, 5'h01, 5'h05, 4'h0, 2'b11});
    chk("hdr_wr", {18'h0, 2'b01, 2'b01, 5'h01, 5'h05}, {18'h0, last_hdr});
    chk("preamble", 32'h0000_0001, {31'h0, preamble_ok});
    chk("phy_wdata", 32'h0000_ABCD, {16'h0, last_wdata});
    rc(`MPC_IDX_DATA, 32'h0000_ABCD, "data_kept");
    mgmt({16'h0000, 5'h01, 5'h05, 4'h0, 2'b01});
    chk("hdr_rd", {18'h0, 2'b01, 2'b10, 5'h01, 5'h05}, {18'h0, last_hdr});
    rc(`MPC_IDX_DATA, 32'h0000_ABCD, "rd_back");
    mgmt({16'h0000, 5'h01, 5'h09, 4'h0, 2'b01});
    rc(`MPC_IDX_DATA, 32'h0000_5A09, "rd_idx");
    mgmt({16'h0000, 5'h02, 5'h09, 4'h0, 2'b01});
    rc(`MPC_IDX_DATA, 32'h0000_FFFF, "rd_absent");
    s_axi_wstrb <= 4'h2;
    wr(`MPC_IDX_DATA, 32'h0000_1234);
    s_axi_wstrb <= 4'hF;
    rc(`MPC_IDX_DATA, 32'h0000_12FF, "data_strb");
    wr(`MPC_IDX_PAUSE, 32'h0003_0002);
    chk("pause_time", 32'h0000_0003, {16'h0, pause_time_value});
    pulse(1'b0);
    for (int n = 0; n < 10 && pause_frame_req !== 1'b1; n++) @(posedge aclk);
    chk("pause_req", 32'h0000_0001, {31'h0, pause_frame_req});
    rc(`MPC_IDX_PAUSE, 32'h0003_0003, "fd_busy");
    for (int n = 0; n < 100 && pause_frame_req !== 1'b0; n++) @(posedge aclk);
    rc(`MPC_IDX_PAUSE, 32'h0003_0002, "fd_idle");
    pulse(1'b1);
    tick(1);
    chk("halt_on", 32'h0000_0001, {31'h0, tx_halt});
    tick(12);
    chk("halt_off", 32'h0000_0000, {31'h0, tx_halt});
    wr(`MPC_IDX_PAUSE, 32'h0003_0000);
    pulse(1'b1);
    tick(1);
    chk("halt_dis", 32'h0000_0000, {31'h0, tx_halt});
    wr(`MPC_IDX_PAUSE, 32'h0003_0002);
    wr(`MPC_IDX_MAC_CTRL, 32'h0000_0002);
    pulse(1'b1);
    tick(1);
    chk("halt_hd", 32'h0000_0000, {31'h0, tx_halt});
    bp_req <= 1'b1;
    tick(2);
    chk("bp_on", 32'h0000_0001, {31'h0, back_pressure});
    rc(`MPC_IDX_PAUSE, 32'h0003_0003, "hd_busy");
    wr(`MPC_IDX_MAC_CTRL, 32'h0000_0000);
    chk("bp_txoff", 32'h0000_0000, {31'h0, back_pressure});
    bp_req <= 1'b0;
    wr(`MPC_IDX_MAC_CTRL, 32'h0000_0001);
    pulse(1'b0);
    tick(2);
    chk("pf_txoff", 32'h0000_0000, {31'h0, pause_frame_req});
    for (int k = 0; k < 5; k++) begin
      wr(`MPC_IDX_PAUSE, {16'h0003, 13'h0, k[0], 2'b10});
      wr(`MPC_IDX_MAC_CTRL, {29'h0, k[1], 2'b11});
      rx_frame_valid <= 1'b1;
      rx_data_in <= 8'h40 + k[7:0];
      rx_is_pause <= (k < 4);
      rx_filter_pass_in <= 1'b1;
      @(posedge aclk);
      rx_frame_valid <= 1'b0;
      @(posedge aclk);
      chk("filter", {31'h0, k[0] | k[1] | (k == 4)}, {31'h0, rx_filter_pass_out});
      chk("rx_data", {24'h0, 8'h40 + k[7:0]}, {24'h0, rx_data_out});
    end
    finish_test;
  end
endmodule // tb_top
bind mpc_top mpc_top_chk #(.SLOT_CYC(SLOT_CYC)) i_mpc_top_chk (.aclk, .aresetn, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .mdc, .mdio_o, .mdio_oe_n, .pause_req, .pause_frame_req,
  .pause_frame_sent, .bp_req, .back_pressure, .tx_halt, .rx_pause_valid, .rx_pause_quanta,
  .rx_frame_valid, .rx_data_in, .rx_is_pause, .rx_filter_pass_in, .rx_frame_valid_out,
  .rx_data_out, .rx_filter_pass_out);
